// *** src/cdm_consts.svh ***
// Sizes and counts of the clock distribution network
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

`define CDM_N_DYN        8
`define CDM_DYN_PER_SIDE 2
`define CDM_DYN_IN       4
`define CDM_DYN_SEL_W    2
`define CDM_N_SRC        24
`define CDM_SRC_W        5
`define CDM_N_GLB        32
`define CDM_GLB_W        5
`define CDM_N_FAB_OTHER  16
`define CDM_N_LOC_FAB    8
`define CDM_LOC_SLOTS    16
`define CDM_LOC_W        6
`define CDM_N_LOC_NET    4
`define CDM_RGN_TB       8
`define CDM_RGN_CORE     4
`define CDM_IF_TB_GLB    14
`define CDM_IF_TB_FAB    2
`define CDM_IF_SIDE      4
`define CDM_IF_SIDE_FAB  2
`define CDM_REGION_ROWS  80
`define CDM_SLICE_ROWS   40
`define CDM_SIDE_W       6

`endif

// *** src/cdm_pkg.sv ***
// Types shared by the clock distribution network
package cdm_pkg;

	// Run-time control of one dynamic multiplexer
	typedef struct packed {
		logic       en;
		logic [1:0] sel;
	} cdm_dyn_ctl_t;

	// Raw clock sources that reach the global buffers
	typedef struct packed {
		logic [7:0] pin;
		logic [3:0] pll;
		logic       osc;
		logic [2:0] lane;
		logic [7:0] core;
	} cdm_src_t;

	typedef enum logic [1:0] {
		CDM_RUN,
		CDM_PARK
	} cdm_dmx_state_t;

endpackage : cdm_pkg

// *** src/cdm_dyn_mux.sv ***
// Glitch-free run-time clock multiplexer with four inputs
`timescale 1ns/1ps
`include "cdm_consts.svh"

module cdm_dyn_mux
	import cdm_pkg::*;
(
	input  wire  logic                       sys_clk,
	input  wire  logic                       rst_n,
	input  wire  logic [`CDM_DYN_IN-1:0]     src,
	input  wire  cdm_dyn_ctl_t               ctl,
	output logic                             clk_out
);

	cdm_dmx_state_t             st_r;
	cdm_dmx_state_t             st_nxt;
	logic [`CDM_DYN_SEL_W-1:0]  cur_r;
	logic [`CDM_DYN_SEL_W-1:0]  cur_nxt;
	logic                       out_r;
	logic                       out_nxt;
	logic [`CDM_DYN_SEL_W-1:0]  want;
	logic                       cur_lvl;
	logic                       want_lvl;

	// RULE2 - enabled select steers
	assign want     = ctl.en ? ctl.sel : '0;
	assign cur_lvl  = src[cur_r];
	assign want_lvl = src[want];

	// RULE13 - leave only when low
	always_comb begin
		st_nxt  = st_r;
		cur_nxt = cur_r;
		out_nxt = 1'b0;
		case (st_r)
			CDM_RUN: begin
				if (want != cur_r && !cur_lvl) begin
					st_nxt = CDM_PARK;
				end else begin
					out_nxt = cur_lvl;
				end
			end
			CDM_PARK: begin
				// Held low until the new source is low too
				if (want_lvl == 1'b0) begin
					cur_nxt = want;
					st_nxt  = CDM_RUN;
				end
			end
			default: begin
				st_nxt = CDM_RUN;
			end
		endcase
	end

	// RULE3 - reset starts on input zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r  <= CDM_RUN;
			cur_r <= '0;
			out_r <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			cur_r <= cur_nxt;
			out_r <= out_nxt;
		end
	end

	assign clk_out = out_r;

endmodule : cdm_dyn_mux

// *** src/cdm_clock_dist.sv ***
// Global, regional and local clock distribution with dynamic muxes
// Functional notes
// RULE1 - Eight run-time muxes, two per side
// RULE2 - Enabled mux passes source picked by select
// RULE3 - User wires earliest clock to input zero
// RULE4 - Global net fed by pins, PLL, oscillator, lanes, core
// RULE5 - PLL regional output only to top/bottom
// RULE6 - Local nets serve 40-row slices per column
// RULE7 - Local net: 16 of global, fabric, regional
// RULE8 - Regional supplies eight top/bottom, four elsewhere
// RULE9 - Local fabric drives clocks and cell enables
// RULE10 - Top/bottom interface: 14 global plus 2 fabric
// RULE11 - Side interface: 4 clocks, at most 2 fabric
// RULE12 - Every network gates on and off glitch-free; the interface local networks here have no gate
// RULE13 - Four-input two-bit mux without runt pulses
`timescale 1ns/1ps
`include "cdm_consts.svh"

module cdm_clock_dist
	import cdm_pkg::*;
#(
	parameter int REGION_ROWS = `CDM_REGION_ROWS,
	parameter int SLICE_ROWS  = `CDM_SLICE_ROWS
)
(
	input  wire  logic                                          sys_clk,
	input  wire  logic                                          rst_n,
	input  wire  cdm_src_t                                      src,
	input  wire  logic [`CDM_N_DYN-1:0][`CDM_DYN_IN-1:0][`CDM_SRC_W-1:0] dyn_map,
	input  wire  cdm_dyn_ctl_t [`CDM_N_DYN-1:0]                 dyn_ctl,
	input  wire  logic [`CDM_N_GLB-1:0][`CDM_GLB_W-1:0]         glb_map,
	input  wire  logic [`CDM_N_GLB-1:0]                         glb_en,
	input  wire  logic                                          pll_regional_output_top,
	input  wire  logic                                          pll_regional_output_bot,
	input  wire  logic [2:0]                                    rgn_en,
	input  wire  logic [`CDM_N_FAB_OTHER-1:0]                   fab_other,
	input  wire  logic [`CDM_N_LOC_FAB-1:0]                     loc_fab,
	input  wire  logic [`CDM_N_LOC_NET-1:0][`CDM_LOC_SLOTS-1:0][`CDM_LOC_W-1:0] loc_map,
	input  wire  logic [`CDM_N_LOC_NET-1:0]                     loc_en,
	input  wire  logic [3:0]                                    cell_slot,
	input  wire  logic [REGION_ROWS-1:0]                        cell_ce,
	input  wire  logic [1:0][`CDM_IF_TB_GLB-1:0][`CDM_GLB_W-1:0] if_tb_map,
	input  wire  logic [1:0][`CDM_IF_TB_FAB-1:0]                if_tb_fab,
	input  wire  logic [1:0][`CDM_IF_SIDE-1:0][`CDM_SIDE_W-1:0] if_side_map,
	input  wire  logic [1:0][`CDM_IF_SIDE_FAB-1:0]              if_side_fab,
	output logic [`CDM_N_DYN-1:0]                               dyn_clk,
	output logic [`CDM_N_GLB-1:0]                               glb_net,
	output logic [`CDM_RGN_TB-1:0]                              rgn_top,
	output logic [`CDM_RGN_TB-1:0]                              rgn_bot,
	output logic [`CDM_RGN_CORE-1:0]                            rgn_core,
	output logic [`CDM_N_LOC_NET-1:0][`CDM_LOC_SLOTS-1:0]       loc_net,
	output logic [REGION_ROWS-1:0]                              cell_clk,
	output logic [REGION_ROWS-1:0]                              cell_ce_out,
	output logic [1:0][`CDM_LOC_SLOTS-1:0]                      if_tb_clk,
	output logic [1:0][`CDM_IF_SIDE-1:0]                        if_side_clk
);

	// ************************************************************
	// Helpers
	// ************************************************************

	// Gate state only moves while the tree is low, so no runt edge
	function automatic logic gate_upd(input logic on, input logic req, input logic lvl);
		gate_upd = lvl ? on : req;
	endfunction : gate_upd

	// Row to local-network slice
	function automatic int slice_of(input int row);
		slice_of = row / SLICE_ROWS;
	endfunction : slice_of

	// ************************************************************
	// Dynamic multiplexers
	// ************************************************************

	localparam int POOL_N = `CDM_N_DYN + `CDM_N_SRC;

	logic [`CDM_N_SRC-1:0]                 src_vec;
	logic [`CDM_N_DYN-1:0][`CDM_DYN_IN-1:0] dyn_in;
	logic [`CDM_N_DYN-1:0]                 dyn_out;
	logic [POOL_N-1:0]                     glb_pool;

	// RULE4 - all global source kinds
	assign src_vec  = src;
	assign glb_pool = {dyn_out, src_vec};

	// RULE1 - eight muxes, side k/2
	genvar gd;
	genvar gi;
	generate
		for (gd = 0; gd < `CDM_N_DYN; gd++) begin : g_dyn
			for (gi = 0; gi < `CDM_DYN_IN; gi++) begin : g_in
				// Out-of-range picks read low
				assign dyn_in[gd][gi] = (int'(dyn_map[gd][gi]) < `CDM_N_SRC) ?
					src_vec[dyn_map[gd][gi]] : 1'b0;
			end
			cdm_dyn_mux u_dmx (
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.src     (dyn_in[gd]),
				.ctl     (dyn_ctl[gd]),
				.clk_out (dyn_out[gd])
			);
		end
	endgenerate

	// ************************************************************
	// Global network
	// ************************************************************

	logic [`CDM_N_GLB-1:0] glb_raw;
	logic [`CDM_N_GLB-1:0] glb_on_r;
	logic [`CDM_N_GLB-1:0] glb_on_nxt;
	logic [`CDM_N_GLB-1:0] glb_r;
	logic [`CDM_N_GLB-1:0] glb_nxt;

	genvar gg;
	generate
		for (gg = 0; gg < `CDM_N_GLB; gg++) begin : g_glb
			// RULE4 - static pick from pool
			assign glb_raw[gg]    = glb_pool[glb_map[gg]];
			// RULE12 - glitch-free tree enable
			assign glb_on_nxt[gg] = gate_upd(glb_on_r[gg], glb_en[gg], glb_raw[gg]);
			assign glb_nxt[gg]    = glb_raw[gg] & glb_on_nxt[gg];
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			glb_on_r <= '0;
			glb_r    <= '0;
		end else begin
			glb_on_r <= glb_on_nxt;
			glb_r    <= glb_nxt;
		end
	end

	// ************************************************************
	// Regional networks
	// ************************************************************

	logic [`CDM_RGN_TB-1:0]   rtop_raw;
	logic [`CDM_RGN_TB-1:0]   rbot_raw;
	logic [`CDM_RGN_CORE-1:0] rcore_raw;
	logic [2:0]               rgn_on_r;
	logic [2:0]               rgn_on_nxt;
	logic [`CDM_RGN_TB-1:0]   rtop_r;
	logic [`CDM_RGN_TB-1:0]   rbot_r;
	logic [`CDM_RGN_CORE-1:0] rcore_r;

	// RULE5 - PLL regional only top/bottom
	// RULE8 - eight top/bottom, four core
	assign rtop_raw  = {src.core[6:0], pll_regional_output_top};
	assign rbot_raw  = {src.core[6:0], pll_regional_output_bot};
	assign rcore_raw = src.core[3:0];

	// RULE12 - regional gating on low
	assign rgn_on_nxt[0] = gate_upd(rgn_on_r[0], rgn_en[0], |rtop_raw);
	assign rgn_on_nxt[1] = gate_upd(rgn_on_r[1], rgn_en[1], |rbot_raw);
	assign rgn_on_nxt[2] = gate_upd(rgn_on_r[2], rgn_en[2], |rcore_raw);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rgn_on_r <= '0;
			rtop_r   <= '0;
			rbot_r   <= '0;
			rcore_r  <= '0;
		end else begin
			rgn_on_r <= rgn_on_nxt;
			rtop_r   <= rtop_raw & {`CDM_RGN_TB{rgn_on_nxt[0]}};
			rbot_r   <= rbot_raw & {`CDM_RGN_TB{rgn_on_nxt[1]}};
			rcore_r  <= rcore_raw & {`CDM_RGN_CORE{rgn_on_nxt[2]}};
		end
	end

	// ************************************************************
	// Core local networks: two slices, memory, multiplier
	// ************************************************************

	localparam int LPOOL_N = `CDM_N_GLB + `CDM_N_FAB_OTHER + `CDM_RGN_CORE + `CDM_N_LOC_FAB;

	logic [LPOOL_N-1:0]                                   loc_pool;
	logic [`CDM_N_LOC_NET-1:0][`CDM_LOC_SLOTS-1:0]        loc_raw;
	logic [`CDM_N_LOC_NET-1:0]                            loc_on_r;
	logic [`CDM_N_LOC_NET-1:0]                            loc_on_nxt;
	logic [`CDM_N_LOC_NET-1:0][`CDM_LOC_SLOTS-1:0]        loc_r;
	logic [REGION_ROWS-1:0]                               cell_clk_r;
	logic [REGION_ROWS-1:0]                               cell_ce_r;

	// RULE7 - global, other-region fabric, regional
	// RULE9 - local fabric in the pool
	assign loc_pool = {loc_fab, rcore_r, fab_other, glb_r};

	genvar gn;
	genvar gs;
	generate
		for (gn = 0; gn < `CDM_N_LOC_NET; gn++) begin : g_loc
			for (gs = 0; gs < `CDM_LOC_SLOTS; gs++) begin : g_slot
				// RULE7 - sixteen slots per net
				assign loc_raw[gn][gs] = (int'(loc_map[gn][gs]) < LPOOL_N) ?
					loc_pool[loc_map[gn][gs]] : 1'b0;
			end
			// RULE12 - local tree gating
			assign loc_on_nxt[gn] = gate_upd(loc_on_r[gn], loc_en[gn], |loc_raw[gn]);
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			loc_on_r <= '0;
			loc_r    <= '0;
		end else begin
			loc_on_r <= loc_on_nxt;
			for (int n = 0; n < `CDM_N_LOC_NET; n++) begin
				loc_r[n] <= loc_raw[n] & {`CDM_LOC_SLOTS{loc_on_nxt[n]}};
			end
		end
	end

	// Cells only see their own slice's net; nets 2 and 3 serve RAM and DSP
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cell_clk_r <= '0;
			cell_ce_r  <= '0;
		end else begin
			for (int r = 0; r < REGION_ROWS; r++) begin
				// RULE6 - 40-row slice pick
				cell_clk_r[r] <= loc_r[slice_of(r)][cell_slot];
			end
			// RULE9 - per-cell clock enable
			cell_ce_r <= cell_ce;
		end
	end

	// ************************************************************
	// Interface local networks
	// ************************************************************

	localparam int SPOOL_N = `CDM_N_GLB + `CDM_RGN_CORE;

	logic [1:0][`CDM_LOC_SLOTS-1:0] if_tb_r;
	logic [1:0][`CDM_IF_SIDE-1:0]   if_side_r;
	logic [1:0][`CDM_LOC_SLOTS-1:0] if_tb_raw;
	logic [1:0][`CDM_IF_SIDE-1:0]   if_side_raw;
	logic [SPOOL_N-1:0]             side_pool;

	assign side_pool = {rcore_r, glb_r};

	genvar ge;
	genvar gk;
	generate
		for (ge = 0; ge < 2; ge++) begin : g_if
			for (gk = 0; gk < `CDM_IF_TB_GLB; gk++) begin : g_tbg
				// RULE10 - 14 from global
				assign if_tb_raw[ge][gk] = glb_r[if_tb_map[ge][gk]];
			end
			// RULE10 - 2 from fabric
			assign if_tb_raw[ge][`CDM_LOC_SLOTS-1 -: `CDM_IF_TB_FAB] = if_tb_fab[ge];
			for (gk = 0; gk < `CDM_IF_SIDE; gk++) begin : g_sd
				// RULE11 - only low two slots take fabric
				if (gk < `CDM_IF_SIDE_FAB) begin : g_fab
					assign if_side_raw[ge][gk] =
						(int'(if_side_map[ge][gk]) < SPOOL_N) ?
						side_pool[if_side_map[ge][gk]] :
						if_side_fab[ge][gk];
				end else begin : g_buf
					assign if_side_raw[ge][gk] =
						(int'(if_side_map[ge][gk]) < SPOOL_N) ?
						side_pool[if_side_map[ge][gk]] : 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			if_tb_r   <= '0;
			if_side_r <= '0;
		end else begin
			if_tb_r   <= if_tb_raw;
			if_side_r <= if_side_raw;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************

	assign dyn_clk     = dyn_out;
	assign glb_net     = glb_r;
	assign rgn_top     = rtop_r;
	assign rgn_bot     = rbot_r;
	assign rgn_core    = rcore_r;
	assign loc_net     = loc_r;
	assign cell_clk    = cell_clk_r;
	assign cell_ce_out = cell_ce_r;
	assign if_tb_clk   = if_tb_r;
	assign if_side_clk = if_side_r;

endmodule : cdm_clock_dist

// *** dv/cdm_fabric_model.sv ***
// Behavioural model of the user fabric feeding the clock network
`timescale 1ns/1ps
module cdm_fabric_model
	import cdm_pkg::*;
(
	input	wire logic	sys_clk,
	input	wire logic	rst_n,
	output	cdm_src_t	src,
	output	logic	pll_regional_output_top,
	output	logic	pll_regional_output_bot,
	output	logic [15:0]	fab_other,
	output	logic [7:0]	loc_fab,
	output	logic [79:0]	cell_ce,
	output	logic [1:0][1:0]	if_tb_fab,
	output	logic [1:0][1:0]	if_side_fab
);
	logic [15:0] cyc_r = 16'h0000;

	// Falling edge keeps the sampling edge clean
	always @(negedge sys_clk) begin
		cyc_r <= rst_n ? cyc_r + 16'h0001 : 16'h0000;
	end

	always_comb begin : p_src
		logic [15:0] t;
		t = 16'h0000;
		for (int i = 0; i < 24; i++) begin
			t = cyc_r - 16'(i);
			src[i] = (cyc_r >= 16'(i)) & t[i % 3 + 1];
		end
	end

	assign pll_regional_output_top = cyc_r[1] ^ cyc_r[3];
	assign pll_regional_output_bot = cyc_r[2];
	assign fab_other = {16{cyc_r[5]}};
	assign loc_fab = {8{cyc_r[6]}};
	assign cell_ce = {10{cyc_r[7:0]}};
	assign if_tb_fab = {cyc_r[6], cyc_r[5], cyc_r[5], cyc_r[6]};
	assign if_side_fab = {cyc_r[5], cyc_r[6], cyc_r[6], cyc_r[5]};
endmodule : cdm_fabric_model

// *** dv/cdm_clock_dist_checker.sv ***
// Port-level assertions for the clock distribution block
`timescale 1ns/1ps
module cdm_clock_dist_checker
	import cdm_pkg::*;
#(
	parameter int REGION_ROWS = 80
)
(
	input	wire logic	sys_clk,
	input	wire logic	rst_n,
	input	wire cdm_src_t	src,
	input	wire logic [7:0][3:0][4:0]	dyn_map,
	input	wire cdm_dyn_ctl_t [7:0]	dyn_ctl,
	input	wire logic [31:0][4:0]	glb_map,
	input	wire logic [31:0]	glb_en,
	input	wire logic	pll_regional_output_top,
	input	wire logic [3:0][15:0][5:0]	loc_map,
	input	wire logic [REGION_ROWS-1:0]	cell_ce,
	input	wire logic [7:0]	dyn_clk,
	input	wire logic [31:0]	glb_net,
	input	wire logic [7:0]	rgn_top,
	input	wire logic [3:0]	rgn_core,
	input	wire logic [3:0][15:0]	loc_net,
	input	wire logic [REGION_ROWS-1:0]	cell_ce_out
);
	logic	raw0;
	logic [1:0]	want0;
	logic [4:0]	stab_r;
	logic [2:0]	up_r;
	cdm_dyn_ctl_t	ctl_r;

	assign raw0 = src[glb_map[0]];
	assign want0 = dyn_ctl[0].en ? dyn_ctl[0].sel : 2'h0;

	// Settling time of mux 0 after its control moves
	always_ff @(posedge sys_clk) begin
		ctl_r <= dyn_ctl[0];
		up_r <= {up_r[1:0], rst_n};
		if (!rst_n || dyn_ctl[0] != ctl_r)
			stab_r <= 5'h00;
		else if (stab_r != 5'h1F)
			stab_r <= stab_r + 5'h01;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ****************
	// Assertions
	// ****************
	a_ce_delay_one: assert property (
		&up_r[1:0] |-> cell_ce_out == $past(cell_ce)) else $error("cell enable lag wrong");
	a_rgn_core_src: assert property (
		$past(src.core[3:0]) == 4'h0 |-> rgn_core == 4'h0) else $error("core regional leak");
	a_rgn_top_src: assert property (
		$past({src.core[6:0], pll_regional_output_top}) == 8'h00 |-> rgn_top == 8'h00)
		else $error("top regional leak");
	a_dyn_no_runt: assert property (
		up_r[0] |-> ((dyn_clk ^ $past(dyn_clk)) & ($past(dyn_clk) ^ $past(dyn_clk, 2))) == 8'h00)
		else $error("short pulse on dynamic mux");
	a_dyn_follow_sel: assert property (
		stab_r == 5'h1F |-> dyn_clk[0] == $past(src[dyn_map[0][want0]]))
		else $error("dynamic mux on wrong input");
	a_glb_gate_pass: assert property (
		&up_r && $past(glb_en[0], 2) && !$past(raw0, 2) |-> glb_net[0] == $past(raw0))
		else $error("global tree does not pass source");
	a_glb_gate_off: assert property (
		&up_r && !$past(glb_en[0], 2) && !$past(raw0, 2) |-> glb_net[0] == 1'h0)
		else $error("global tree not gated off");
	a_loc_zero_src: assert property (
		loc_map[0][0] == 6'h00 && !$past(glb_net[0]) |-> !loc_net[0][0])
		else $error("local slot shows foreign signal");
endmodule : cdm_clock_dist_checker

bind cdm_clock_dist cdm_clock_dist_checker #(.REGION_ROWS(REGION_ROWS)) u_chk (.sys_clk, .rst_n,
	.src, .dyn_map, .dyn_ctl, .glb_map, .glb_en, .pll_regional_output_top, .loc_map, .cell_ce,
	.dyn_clk, .glb_net, .rgn_top, .rgn_core, .loc_net, .cell_ce_out);

// *** dv/cdm_clock_dist_bench.sv ***
// Self-checking bench for the clock distribution block
`timescale 1ns/1ps
module cdm_clock_dist_bench
	import cdm_pkg::*;
;
	logic	sys_clk = 1'h0;
	logic	rst_n, pll_regional_output_top, pll_regional_output_bot, top_r, bot_r;
	cdm_src_t	src, src1_r, src2_r, src3_r;
	logic [7:0][3:0][4:0]	dyn_map;
	cdm_dyn_ctl_t [7:0]	dyn_ctl;
	logic [31:0][4:0]	glb_map;
	logic [31:0]	glb_en, glb_net;
	logic [2:0]	rgn_en;
	logic [15:0]	fab_other;
	logic [7:0]	loc_fab, dyn_clk, rgn_top, rgn_bot;
	logic [3:0][15:0][5:0]	loc_map;
	logic [3:0]	loc_en, cell_slot, rgn_core;
	logic [79:0]	cell_ce, ce_r, cell_clk, cell_ce_out;
	logic [1:0][13:0][4:0]	if_tb_map;
	logic [1:0][1:0]	if_tb_fab, if_side_fab, fab1_r, side_r;
	logic [1:0][3:0][5:0]	if_side_map;
	logic [3:0][15:0]	loc_net;
	logic [1:0][15:0]	if_tb_clk;
	logic [1:0][3:0]	if_side_clk;
	int	num_errors = 0;
	int	total_checks = 0;
	int	cyc_cnt = 0;

	cdm_fabric_model u_fab (.sys_clk, .rst_n, .src, .pll_regional_output_top,
		.pll_regional_output_bot, .fab_other, .loc_fab, .cell_ce, .if_tb_fab, .if_side_fab);
	cdm_clock_dist u_dut (.sys_clk, .rst_n, .src, .dyn_map, .dyn_ctl, .glb_map, .glb_en,
		.pll_regional_output_top, .pll_regional_output_bot, .rgn_en, .fab_other, .loc_fab,
		.loc_map, .loc_en, .cell_slot, .cell_ce, .if_tb_map, .if_tb_fab, .if_side_map,
		.if_side_fab, .dyn_clk, .glb_net, .rgn_top, .rgn_bot, .rgn_core, .loc_net, .cell_clk,
		.cell_ce_out, .if_tb_clk, .if_side_clk);

	always #2.5 sys_clk = ~sys_clk;

	// Delayed copies of stimulus give expected levels
	always @(posedge sys_clk) begin
		src1_r <= src;
		src2_r <= src1_r;
		src3_r <= src2_r;
		top_r <= pll_regional_output_top;
		bot_r <= pll_regional_output_bot;
		ce_r <= cell_ce;
		fab1_r <= if_tb_fab;
		side_r <= if_side_fab;
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			num_errors++;
			final_report();
		end
	end

	// ****************
	// Scenarios
	// ****************
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic t_dyn();
		for (int s = 0; s < 5; s++) begin
			for (int k = 0; k < 8; k++)
				dyn_ctl[k] = (s < 4) ? {1'h1, 2'(s)} : 3'h3;
			repeat (40) @(negedge sys_clk);
			repeat (6) begin
				@(negedge sys_clk);
				for (int k = 0; k < 8; k++) begin
					check("dyn_clk", dyn_clk[k], src1_r[k + 4 * (s % 4)]);
					check("glb_dyn", glb_net[24 + k], src2_r[k + 4 * (s % 4)]);
				end
			end
		end
	endtask : t_dyn

	task automatic t_glb();
		for (int e = 0; e < 2; e++) begin
			glb_en[0] = 1'(e);
			repeat (20) @(negedge sys_clk);
			repeat (8) begin
				@(negedge sys_clk);
				for (int k = 0; k < 24; k++)
					check("glb_net", glb_net[k], (k > 0 || e > 0) & src1_r[k]);
			end
		end
	endtask : t_glb

	task automatic t_rgn_loc();
		repeat (12) begin
			@(negedge sys_clk);
			check("rgn_top", rgn_top, {src1_r.core[6:0], top_r});
			check("rgn_bot", rgn_bot, {src1_r.core[6:0], bot_r});
			check("rgn_core", rgn_core, src1_r.core[3:0]);
			for (int j = 0; j < 16; j++) begin
				check("loc0", loc_net[0][j], src2_r[j]);
				check("loc1", loc_net[1][j], src2_r[j + 8]);
			end
			check("loc2", loc_net[2], 16'h0000);
			check("cell0", cell_clk[0], src3_r[3]);
			check("cell40", cell_clk[40], src3_r[11]);
			check("cell_ce", cell_ce_out, ce_r);
			for (int s = 0; s < 2; s++) begin
				for (int j = 0; j < 14; j++)
					check("if_tb", if_tb_clk[s][j], src2_r[j + 8 * s]);
				check("if_tb_fab", if_tb_clk[s][15:14], fab1_r[s]);
				check("if_side", if_side_clk[s], {src2_r[5], 1'h0, src2_r[0], side_r[s][0]});
			end
		end
	endtask : t_rgn_loc

	task automatic t_rgn_off();
		rgn_en = 3'h3;
		repeat (40) @(negedge sys_clk);
		repeat (8) begin
			@(negedge sys_clk);
			check("rgn_core_off", rgn_core, 4'h0);
			check("rgn_top_on", rgn_top, {src1_r.core[6:0], top_r});
		end
	endtask : t_rgn_off

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	initial begin
		rst_n = 1'h0;
		dyn_ctl = '0;
		glb_en = '1;
		rgn_en = 3'h7;
		loc_en = 4'hF;
		cell_slot = 4'h3;
		loc_map = '1;
		for (int k = 0; k < 32; k++)
			glb_map[k] = 5'(k);
		for (int j = 0; j < 16; j++) begin
			dyn_map[j / 4 * 2 % 8 + j % 2][j / 2 % 2 + j / 8 * 2] = 5'(j / 4 * 2 % 8 + j % 2 + 4 * (j / 2 % 2 + j / 8 * 2));
			loc_map[0][j] = 6'(j);
			loc_map[1][j] = 6'(j + 8);
		end
		for (int k = 0; k < 8; k++)
			for (int j = 0; j < 4; j++)
				dyn_map[k][j] = 5'(k + 4 * j);
		for (int s = 0; s < 2; s++) begin
			if_side_map[s] = {6'h05, 6'h3F, 6'h20, 6'h24};
			for (int j = 0; j < 14; j++)
				if_tb_map[s][j] = 5'(j + 8 * s);
		end
		repeat (3) @(negedge sys_clk);
		check("rst_out", {dyn_clk, glb_net, rgn_core}, 64'h0);
		repeat (3) @(negedge sys_clk);
		rst_n <= 1'h1;
		repeat (4) @(negedge sys_clk);
		t_dyn();
		t_glb();
		t_rgn_loc();
		t_rgn_off();
		final_report();
	end
endmodule : cdm_clock_dist_bench
